// file: logic/ubb_bulk_ep.sv
// Bulk OUT and IN endpoint buffers with Wishbone registers and auto pointers
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R01: OUT endpoint holds at most two packets
// R02: Both OUT buffers full: NAK further OUT
// R03: Space NAK sets the PING-NAK request
// R04: Re-arm discards oldest packet, frees buffer
// R05: Firmware arms OUT by writing skip twice; OUT accepts from reset, skip on empty is ignored
// R06: OUT byte count readable, high above low
// R07: Status shows OUT empty, IN full
// R08: IN commit by count, low byte last
// R09: Setup enable bit turns auto pointers on
// R10: Auto data access advances pointer by one
// R11: Config selects direction, bulk, double buffering
// R12: Packets 512 bytes high speed, 64 full
// R13: Re-arming on NAK keeps latest two packets
// R14: PING answered NAK when full, else ACK
// R15: Writing one clears the PING-NAK request
// R16: Count bit 7 write arms the endpoint
// R17: Firmware waits between config/count writes
// R18: Empty clears on store, sets when re-armed
module ubb_bulk_ep import ubb_pkg::*; #(
	parameter bit HIGH_SPEED = 1'b1
) (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	output logic irq_out,
	input wire ubb_out_link_t out_link_in,
	output ubb_hs_t hs_out,
	input wire logic in_rd_in,
	input wire logic in_done_in,
	output logic in_ready_out,
	output logic [15:0] in_len_out,
	output logic [7:0] in_data_out
);
	localparam int PKT = HIGH_SPEED ? UBB_PKT_HS : UBB_PKT_FS; // R12
	localparam int AW = $clog2(PKT);
	localparam int CW = AW + 1;
	localparam int PW = AW + 1;

	logic [7:0] out_mem [0:2*PKT-1];
	logic [7:0] in_mem [0:2*PKT-1];
	logic [CW-1:0] out_cnt_ff [0:1];
	logic [CW-1:0] in_cnt_ff [0:1];

	logic ack_ff;
	logic [31:0] dat_ff;
	logic [7:0] out_cfg_ff;
	logic [7:0] in_cfg_ff;
	logic [7:0] aptr_setup_ff;
	logic [PW-1:0] aptr1_ff;
	logic [PW-1:0] aptr2_ff;
	logic [7:0] in_cnt_hi_ff;
	logic [UBB_IRQ_W-1:0] irq_ff;
	logic [UBB_IRQ_W-1:0] mask_ff;
	ubb_rx_state_t rx_ff;
	logic [CW-1:0] rx_idx_ff;
	logic [1:0] out_occ_ff;
	logic out_fill_ff;
	logic out_head_ff;
	logic [1:0] in_occ_ff;
	logic in_fill_ff;
	logic in_head_ff;
	logic [AW-1:0] in_idx_ff;
	ubb_hs_t hs_ff;
	logic [7:0] in_data_ff;

	// Bus decode: side effects happen once, in the cycle the ack is formed
	wire req = wb_cyc_in & wb_stb_in;
	wire acc = req & ~ack_ff;
	wire wr = acc & wb_we_in & wb_sel_in[0];
	wire rd = acc & ~wb_we_in;
	wire [7:0] off = {wb_adr_in[7:2], 2'b00};
	wire [7:0] wdat = wb_dat_in[7:0];
	wire aptr_on = aptr_setup_ff[UBB_APTR_EN_BIT]; // R09

	// Endpoint configuration steers direction, type and depth
	wire out_on = out_cfg_ff[UBB_CFG_VALID] & ~out_cfg_ff[UBB_CFG_DIR_IN]
		& (out_cfg_ff[UBB_CFG_TYPE_LO+:2] == UBB_TYPE_BULK); // R11
	wire in_on = in_cfg_ff[UBB_CFG_VALID] & in_cfg_ff[UBB_CFG_DIR_IN]
		& (in_cfg_ff[UBB_CFG_TYPE_LO+:2] == UBB_TYPE_BULK); // R11
	wire [1:0] out_depth =
		(out_cfg_ff[UBB_CFG_BUF_LO+:2] == UBB_BUF_DOUBLE) ? 2'h2 : 2'h1;
	wire [1:0] in_depth =
		(in_cfg_ff[UBB_CFG_BUF_LO+:2] == UBB_BUF_DOUBLE) ? 2'h2 : 2'h1;

	// OUT side
	wire out_free = out_on & (out_occ_ff < out_depth); // R01
	wire out_empty = out_occ_ff == 2'h0; // R18
	wire out_full = ~out_free;
	wire rx_idle = rx_ff == UBB_RX_IDLE;
	wire tok_ok = rx_idle & out_link_in.token & out_free;
	wire tok_nak = rx_idle & out_link_in.token & ~out_free; // R02
	wire ping_ack = out_link_in.ping & out_free; // R14
	wire ping_nak = out_link_in.ping & ~out_free; // R14
	wire rx_byte = (rx_ff == UBB_RX_RECV) & out_link_in.valid
		& (rx_idx_ff < CW'(PKT));
	wire commit = (rx_ff == UBB_RX_RECV) & out_link_in.done
		& ~out_link_in.bad;
	// Skip on an empty endpoint only confirms it is armed
	wire skip = wr & (off == UBB_ADR_OUT_CNT_LO) & wdat[UBB_SKIP_BIT]
		& ~out_empty; // R16
	wire [1:0] nxt_out_occ = out_occ_ff + {1'b0, commit} - {1'b0, skip};
	wire [CW-1:0] out_cnt = out_empty ? '0 : out_cnt_ff[out_head_ff];
	// Widened so the high byte exists for the 64 byte variant as well
	wire [15:0] out_cnt16 = 16'(out_cnt);

	// IN side: the low byte write is the commit
	wire in_full = ~in_on | (in_occ_ff >= in_depth); // R07
	wire in_empty = in_occ_ff == 2'h0;
	wire in_commit = wr & (off == UBB_ADR_IN_CNT_LO) & ~in_full; // R08
	wire in_rel = in_done_in & ~in_empty;
	wire in_rd = in_rd_in & ~in_empty;
	wire [1:0] nxt_in_occ = in_occ_ff + {1'b0, in_commit} - {1'b0, in_rel};
	wire [15:0] in_cnt_new = {in_cnt_hi_ff, wdat};

	// Auto pointer data ports
	wire dat1 = acc & (off == UBB_ADR_APTR1_DAT);
	wire dat2 = acc & (off == UBB_ADR_APTR2_DAT);
	wire [PW-1:0] ptr = dat1 ? aptr1_ff : aptr2_ff;
	wire [7:0] ptr_byte = ptr[PW-1]
		? in_mem[{in_fill_ff, ptr[AW-1:0]}]
		: out_mem[{out_head_ff, ptr[AW-1:0]}];
	// Only IN buffers take firmware data; OUT buffers are host-written
	wire ptr_wr = (dat1 | dat2) & wb_we_in & wb_sel_in[0] & ptr[PW-1];

	// Interrupts: set wins over a same-cycle clear
	wire [UBB_IRQ_W-1:0] irq_set = {in_rel, commit, tok_nak | ping_nak};
	wire [UBB_IRQ_W-1:0] irq_clr = (wr & (off == UBB_ADR_NAK_IRQ))
		? wdat[UBB_IRQ_W-1:0] : '0; // R15
	wire [UBB_IRQ_W-1:0] nxt_irq = (irq_ff & ~irq_clr) | irq_set; // R03

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (off)
			UBB_ADR_STATUS: begin
				rd_mux[UBB_ST_OUT_EMPTY] = out_empty; // R07
				rd_mux[UBB_ST_OUT_FULL] = out_full;
				rd_mux[UBB_ST_IN_EMPTY] = in_empty;
				rd_mux[UBB_ST_IN_FULL] = in_full; // R07
			end
			UBB_ADR_OUT_CFG: rd_mux[7:0] = out_cfg_ff;
			UBB_ADR_IN_CFG: rd_mux[7:0] = in_cfg_ff;
			UBB_ADR_OUT_CNT_HI: rd_mux[7:0] = out_cnt16[15:8]; // R06
			UBB_ADR_OUT_CNT_LO: rd_mux[7:0] = out_cnt16[7:0]; // R06
			UBB_ADR_IN_CNT_HI: rd_mux[7:0] = in_cnt_hi_ff;
			UBB_ADR_APTR_SETUP: rd_mux[7:0] = aptr_setup_ff;
			UBB_ADR_APTR1: rd_mux[PW-1:0] = aptr1_ff;
			UBB_ADR_APTR2: rd_mux[PW-1:0] = aptr2_ff;
			UBB_ADR_APTR1_DAT: rd_mux[7:0] = ptr_byte; // R10
			UBB_ADR_APTR2_DAT: rd_mux[7:0] = ptr_byte; // R10
			UBB_ADR_NAK_IRQ: rd_mux[UBB_IRQ_W-1:0] = irq_ff;
			UBB_ADR_IRQ_MASK: rd_mux[UBB_IRQ_W-1:0] = mask_ff;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Bus answer: one wait state, unmapped reads return zero
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= acc;
			if (rd) begin
				dat_ff <= rd_mux;
			end
		end
	end

	// Software-written control registers
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			out_cfg_ff <= UBB_OUT_CFG_RST; // R11
			in_cfg_ff <= UBB_IN_CFG_RST; // R11
			aptr_setup_ff <= UBB_APTR_RST;
			in_cnt_hi_ff <= 8'h00;
			mask_ff <= UBB_IRQ_RST;
			irq_ff <= UBB_IRQ_RST;
		end else begin
			irq_ff <= nxt_irq;
			if (wr && off == UBB_ADR_OUT_CFG)
				out_cfg_ff <= wdat;
			if (wr && off == UBB_ADR_IN_CFG)
				in_cfg_ff <= wdat;
			if (wr && off == UBB_ADR_APTR_SETUP)
				aptr_setup_ff <= wdat; // R09
			if (wr && off == UBB_ADR_IN_CNT_HI)
				in_cnt_hi_ff <= wdat; // R08
			if (wr && off == UBB_ADR_IRQ_MASK)
				mask_ff <= wdat[UBB_IRQ_W-1:0];
		end
	end

	// Auto pointers step only while enabled
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			aptr1_ff <= '0;
			aptr2_ff <= '0;
		end else begin
			if (wb_we_in && wr && off == UBB_ADR_APTR1)
				aptr1_ff <= wb_dat_in[PW-1:0];
			else if (dat1 && aptr_on)
				aptr1_ff <= aptr1_ff + 1'b1; // R10
			if (wb_we_in && wr && off == UBB_ADR_APTR2)
				aptr2_ff <= wb_dat_in[PW-1:0];
			else if (dat2 && aptr_on)
				aptr2_ff <= aptr2_ff + 1'b1; // R10
		end
	end

	// Packet storage; memories carry no reset
	always_ff @(posedge clk_sys_in) begin
		if (rx_byte)
			out_mem[{out_fill_ff, rx_idx_ff[AW-1:0]}] <= out_link_in.data;
		if (ptr_wr)
			in_mem[{in_fill_ff, ptr[AW-1:0]}] <= wdat;
		if (commit)
			out_cnt_ff[out_fill_ff] <= rx_idx_ff; // R06
		if (in_commit)
			in_cnt_ff[in_fill_ff] <= in_cnt_new[CW-1:0]; // R08
	end

	// OUT receive sequence and handshakes
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			rx_ff <= UBB_RX_IDLE;
			rx_idx_ff <= '0;
			hs_ff <= '0;
		end else begin
			hs_ff.valid <= tok_nak | ping_ack | ping_nak | commit;
			hs_ff.ack <= ping_ack | commit; // R14
			case (rx_ff)
				UBB_RX_IDLE: begin
					rx_idx_ff <= '0;
					if (tok_ok)
						rx_ff <= UBB_RX_RECV;
				end
				UBB_RX_RECV: begin
					if (rx_byte)
						rx_idx_ff <= rx_idx_ff + 1'b1;
					if (out_link_in.done)
						rx_ff <= UBB_RX_IDLE;
				end
				default: rx_ff <= UBB_RX_IDLE;
			endcase
		end
	end

	// OUT buffer ring: host fills at one end, skip drops the oldest
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			out_occ_ff <= 2'h0;
			out_fill_ff <= 1'b0;
			out_head_ff <= 1'b0;
		end else begin
			out_occ_ff <= nxt_out_occ; // R01
			if (commit)
				out_fill_ff <= ~out_fill_ff;
			if (skip) // R13
				out_head_ff <= ~out_head_ff; // R04
		end
	end

	// IN buffer ring: firmware commits, host drains
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			in_occ_ff <= 2'h0;
			in_fill_ff <= 1'b0;
			in_head_ff <= 1'b0;
			in_idx_ff <= '0;
			in_data_ff <= 8'h00;
		end else begin
			in_occ_ff <= nxt_in_occ;
			if (in_commit)
				in_fill_ff <= ~in_fill_ff; // R08
			if (in_rel) begin
				in_head_ff <= ~in_head_ff;
				in_idx_ff <= '0;
			end else if (in_rd) begin
				in_idx_ff <= in_idx_ff + 1'b1;
			end
			if (in_rd)
				in_data_ff <= in_mem[{in_head_ff, in_idx_ff}];
		end
	end

	assign wb_ack_out = ack_ff;
	assign wb_dat_out = dat_ff;
	assign irq_out = |(irq_ff & mask_ff);
	assign hs_out = hs_ff;
	assign in_ready_out = ~in_empty;
	assign in_len_out = in_empty ? 16'h0000
		: {{(16-CW){1'b0}}, in_cnt_ff[in_head_ff]};
	assign in_data_out = in_data_ff;
endmodule : ubb_bulk_ep
`default_nettype wire

// file: inc/ubb_pkg.sv
// Shared constants, link carriers and states of the bulk endpoint buffers
`default_nettype none
package ubb_pkg;
	// Packet sizes of the two device variants
	localparam int UBB_PKT_HS = 512;
	localparam int UBB_PKT_FS = 64;

	// Register byte offsets on the Wishbone bus
	localparam logic [7:0] UBB_ADR_STATUS = 8'h00;
	localparam logic [7:0] UBB_ADR_OUT_CFG = 8'h04;
	localparam logic [7:0] UBB_ADR_IN_CFG = 8'h08;
	localparam logic [7:0] UBB_ADR_OUT_CNT_HI = 8'h0c;
	localparam logic [7:0] UBB_ADR_OUT_CNT_LO = 8'h10;
	localparam logic [7:0] UBB_ADR_IN_CNT_HI = 8'h14;
	localparam logic [7:0] UBB_ADR_IN_CNT_LO = 8'h18;
	localparam logic [7:0] UBB_ADR_APTR_SETUP = 8'h1c;
	localparam logic [7:0] UBB_ADR_APTR1 = 8'h20;
	localparam logic [7:0] UBB_ADR_APTR2 = 8'h24;
	localparam logic [7:0] UBB_ADR_APTR1_DAT = 8'h28;
	localparam logic [7:0] UBB_ADR_APTR2_DAT = 8'h2c;
	localparam logic [7:0] UBB_ADR_NAK_IRQ = 8'h30;
	localparam logic [7:0] UBB_ADR_IRQ_MASK = 8'h34;

	// Endpoint configuration layout and reset values
	localparam logic [7:0] UBB_OUT_CFG_RST = 8'ha2;
	localparam logic [7:0] UBB_IN_CFG_RST = 8'he2;
	localparam int UBB_CFG_VALID = 7;
	localparam int UBB_CFG_DIR_IN = 6;
	localparam int UBB_CFG_TYPE_LO = 4;
	localparam int UBB_CFG_BUF_LO = 0;
	localparam logic [1:0] UBB_TYPE_BULK = 2'h2;
	localparam logic [1:0] UBB_BUF_DOUBLE = 2'h2;

	// Byte count skip bit and auto pointer enable bit
	localparam int UBB_SKIP_BIT = 7;
	localparam int UBB_APTR_EN_BIT = 0;
	localparam logic [7:0] UBB_APTR_RST = 8'h00;

	// Endpoint status flag positions
	localparam int UBB_ST_OUT_EMPTY = 0;
	localparam int UBB_ST_OUT_FULL = 1;
	localparam int UBB_ST_IN_EMPTY = 2;
	localparam int UBB_ST_IN_FULL = 3;

	// Interrupt request bit positions
	localparam int UBB_IRQ_W = 3;
	localparam int UBB_IRQ_PING_NAK = 0;
	localparam int UBB_IRQ_OUT_PKT = 1;
	localparam int UBB_IRQ_IN_SENT = 2;
	localparam logic [UBB_IRQ_W-1:0] UBB_IRQ_RST = 3'h0;

	// Strobes from the USB serial engine for the OUT endpoint
	typedef struct packed {
		logic token;
		logic ping;
		logic valid;
		logic [7:0] data;
		logic done;
		logic bad;
	} ubb_out_link_t;

	// Handshake answer to the serial engine
	typedef struct packed {
		logic valid;
		logic ack;
	} ubb_hs_t;

	typedef enum logic {UBB_RX_IDLE, UBB_RX_RECV} ubb_rx_state_t;
endpackage : ubb_pkg
`default_nettype wire

// file: sim/ubb_bulk_ep_checker.sv
// Port checker for the bulk endpoint buffers
`timescale 1ns/1ns
`default_nettype none
module ubb_ep_checker import ubb_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_ack_out,
	input wire ubb_out_link_t out_link_in,
	input wire ubb_hs_t hs_out,
	input wire logic in_rd_in,
	input wire logic in_ready_out,
	input wire logic [15:0] in_len_out,
	input wire logic [7:0] in_data_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	sequence s_req;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	sequence s_good_end;
		out_link_in.done && !out_link_in.bad;
	endsequence
	property p_ack; s_req |=> wb_ack_out; endproperty
	property p_ack_once; wb_ack_out |=> !wb_ack_out; endproperty
	property p_idle; !wb_cyc_in |=> !wb_ack_out; endproperty
	property p_ping; out_link_in.ping |=> hs_out.valid; endproperty
	property p_good; s_good_end |=> hs_out.valid && hs_out.ack; endproperty
	property p_hs; hs_out.valid |=> !hs_out.valid; endproperty
	property p_hold; !in_rd_in |=> $stable(in_data_out); endproperty
	property p_none; !in_ready_out |-> in_len_out == 16'h0; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	a_ack_once: assert property (p_ack_once) else $error("ack too long");
	a_idle: assert property (p_idle) else $error("ack without request");
	a_ping: assert property (p_ping) else $error("ping unanswered");
	a_good: assert property (p_good) else $error("packet not acked");
	a_hs: assert property (p_hs) else $error("handshake too long");
	a_hold: assert property (p_hold) else $error("IN byte moved");
	a_none: assert property (p_none) else $error("stale IN count");
endmodule : ubb_ep_checker
bind ubb_bulk_ep ubb_ep_checker u_chk (.clk_sys_in, .reset_in, .wb_cyc_in,
	.wb_stb_in, .wb_ack_out, .out_link_in, .hs_out, .in_rd_in,
	.in_ready_out, .in_len_out, .in_data_out);
`default_nettype wire

// file: sim/ubb_host_model.sv
// Host side model: OUT tokens, bytes and pings, IN byte draining
`timescale 1ns/1ns
`default_nettype none
module ubb_host_model import ubb_pkg::*; (
	input wire logic clk_sys_in,
	input wire ubb_hs_t hs_in,
	input wire logic [7:0] dat_in,
	output ubb_out_link_t link_out,
	output logic rd_out,
	output logic done_out
);
	initial begin
		link_out = '0;
		rd_out = 1'b0;
		done_out = 1'b0;
	end
	// A NAK right after the token ends the attempt with no data
	task automatic send(input int n, input logic [7:0] b, output ubb_hs_t h);
		@(posedge clk_sys_in) link_out.token <= 1'b1;
		@(posedge clk_sys_in) link_out.token <= 1'b0;
		@(posedge clk_sys_in) h = hs_in;
		if (h.valid !== 1'b1) begin
			for (int i = 0; i < n; i++) begin
				link_out.valid <= 1'b1;
				link_out.data <= b + 8'(i);
				@(posedge clk_sys_in);
			end
			link_out.valid <= 1'b0;
			// Released data line must not keep the last byte
			link_out.data <= ~link_out.data;
			link_out.done <= 1'b1;
			@(posedge clk_sys_in) link_out.done <= 1'b0;
			@(posedge clk_sys_in) h = hs_in;
		end
	endtask : send
	task automatic ping(output ubb_hs_t h);
		@(posedge clk_sys_in) link_out.ping <= 1'b1;
		@(posedge clk_sys_in) link_out.ping <= 1'b0;
		@(posedge clk_sys_in) h = hs_in;
	endtask : ping
	task automatic rd(output logic [7:0] q);
		@(posedge clk_sys_in) rd_out <= 1'b1;
		@(posedge clk_sys_in) rd_out <= 1'b0;
		@(posedge clk_sys_in) q = dat_in;
	endtask : rd
	task automatic fin();
		@(posedge clk_sys_in) done_out <= 1'b1;
		@(posedge clk_sys_in) done_out <= 1'b0;
	endtask : fin
endmodule : ubb_host_model
`default_nettype wire

// file: sim/tb_usb_bulk_endpoint_buffers.sv
// Self-checking bench for the bulk endpoint buffers
`timescale 1ns/1ns
`default_nettype none
module tb_usb_bulk_endpoint_buffers import ubb_pkg::*;;
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic ack, irq, rd, dn, rdy;
	logic [15:0] len;
	logic [7:0] idat;
	ubb_out_link_t link;
	ubb_hs_t hs;
	int n_fail = 0, checks_done = 0;
	always #50 clk = ~clk;
	// Small packets keep the buffers short
	ubb_bulk_ep #(.HIGH_SPEED(1'b0)) dut (.clk_sys_in(clk), .reset_in(rst),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .irq_out(irq), .out_link_in(link), .hs_out(hs),
		.in_rd_in(rd), .in_done_in(dn), .in_ready_out(rdy),
		.in_len_out(len), .in_data_out(idat));
	ubb_host_model host (.clk_sys_in(clk), .hs_in(hs), .dat_in(idat),
		.link_out(link), .rd_out(rd), .done_out(dn));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic rdk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 8'h00);
		chk(rdat, e);
	endtask : rdk
	task automatic t_reset();
		rdk(UBB_ADR_STATUS, 32'h5);
		rdk(UBB_ADR_OUT_CFG, 32'ha2);
		rdk(UBB_ADR_IN_CFG, 32'he2);
		rdk(8'h3c, 32'h0);
		chk(irq, 1'b0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_out();
		ubb_hs_t h;
		wb(1'b1, UBB_ADR_OUT_CNT_LO, 8'h80);
		wb(1'b1, UBB_ADR_OUT_CNT_LO, 8'h80);
		wb(1'b1, UBB_ADR_IRQ_MASK, 8'h01);
		host.send(3, 8'h10, h);
		chk(h, 2'h3);
		host.send(5, 8'h20, h);
		chk(h, 2'h3);
		rdk(UBB_ADR_STATUS, 32'h6);
		host.send(4, 8'h30, h);
		chk(h, 2'h2);
		rdk(UBB_ADR_NAK_IRQ, 32'h3);
		chk(irq, 1'b1);
		host.ping(h);
		chk(h, 2'h2);
		wb(1'b1, UBB_ADR_OUT_CNT_LO, 8'h80);
		wb(1'b1, UBB_ADR_NAK_IRQ, 8'h07);
		chk(irq, 1'b0);
		host.ping(h);
		chk(h, 2'h3);
		host.send(4, 8'h30, h);
		chk(h, 2'h3);
		rdk(UBB_ADR_OUT_CNT_LO, 32'h5);
		rdk(UBB_ADR_OUT_CNT_HI, 32'h0);
		$display("test out done");
	endtask : t_out
	task automatic t_copy();
		logic [7:0] q;
		wb(1'b1, UBB_ADR_APTR_SETUP, 8'h01);
		wb(1'b1, UBB_ADR_APTR1, 8'h00);
		wb(1'b1, UBB_ADR_APTR2, 8'h40);
		for (int i = 0; i < 5; i++) begin
			rdk(UBB_ADR_APTR1_DAT, 32'h20 + i);
			wb(1'b1, UBB_ADR_APTR2_DAT, rdat[7:0]);
		end
		wb(1'b1, UBB_ADR_IN_CNT_HI, 8'h00);
		wb(1'b1, UBB_ADR_IN_CNT_LO, 8'h05);
		chk(rdy, 1'b1);
		chk(len, 16'h5);
		rdk(UBB_ADR_STATUS, 32'h2);
		for (int i = 0; i < 5; i++) begin
			host.rd(q);
			chk(q, 8'h20 + 8'(i));
		end
		host.fin();
		wb(1'b1, UBB_ADR_OUT_CNT_LO, 8'h80);
		rdk(UBB_ADR_OUT_CNT_LO, 32'h4);
		wb(1'b1, UBB_ADR_OUT_CNT_LO, 8'h80);
		rdk(UBB_ADR_STATUS, 32'h5);
		$display("test copy done");
	endtask : t_copy
	task automatic t_cfg();
		ubb_hs_t h;
		wb(1'b1, UBB_ADR_OUT_CFG, 8'ha0);
		rdk(UBB_ADR_OUT_CFG, 32'ha0);
		host.send(70, 8'h40, h);
		chk(h, 2'h3);
		rdk(UBB_ADR_OUT_CNT_LO, 32'h40);
		rdk(UBB_ADR_OUT_CNT_HI, 32'h0);
		host.send(2, 8'h50, h);
		chk(h, 2'h2);
		rdk(UBB_ADR_STATUS, 32'h6);
		rdk(UBB_ADR_NAK_IRQ, 32'h7);
		chk(irq, 1'b1);
		wb(1'b1, UBB_ADR_OUT_CFG, 8'ha2);
		wb(1'b1, UBB_ADR_OUT_CNT_LO, 8'h80);
		rdk(UBB_ADR_STATUS, 32'h5);
		$display("test config done");
	endtask : t_cfg
	task automatic summarize();
		$display("checks=%0d fails=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_out();
		t_copy();
		t_cfg();
		summarize();
	end
	initial begin
		#3000000;
		n_fail++;
		summarize();
	end
endmodule : tb_usb_bulk_endpoint_buffers
`default_nettype wire
